// ===== core/lbist_pkg.sv
package lbist_pkg;

// ----------------------------------------
// widths and counts
// ----------------------------------------
localparam int unsigned CLK_HZ = 20_000_000;
localparam int unsigned RUNS_LOW = 1700;
localparam int unsigned RUNS_HIGH = 300;
localparam int unsigned CYC_LOW = 46;
localparam int unsigned CYC_HIGH = 61;
localparam int unsigned TIMEOUT_US = 10;
localparam int unsigned TIMEOUT_CYC = (TIMEOUT_US * (CLK_HZ / 1_000_000) > 0) ?
    TIMEOUT_US * (CLK_HZ / 1_000_000) : 1;
localparam int unsigned RUN_CNT_W = 12;
localparam int unsigned CYC_CNT_W = 16;

// ----------------------------------------
// register map (word index of plain port)
// ----------------------------------------
localparam logic [3:0] ADDR_CTRL = 4'h0;
localparam logic [3:0] ADDR_STATUS = 4'h1;
localparam logic [3:0] ADDR_COUNT = 4'h2;
localparam logic [3:0] ADDR_SEM = 4'h3;
localparam logic [3:0] ADDR_RETADDR = 4'h4;
localparam logic [3:0] ADDR_INJECT = 4'h5;

// ctrl write bits
localparam int unsigned CTRL_INIT = 0;
localparam int unsigned CTRL_COV_HIGH = 1;
localparam int unsigned CTRL_MICRO = 2;

// status bit positions
localparam int unsigned ST_DONE = 0;
localparam int unsigned ST_MICRO_DONE = 1;
localparam int unsigned ST_NMI = 2;
localparam int unsigned ST_FAIL = 3;
localparam int unsigned ST_COMP_FAIL = 4;
localparam int unsigned ST_TO_FAIL = 5;
localparam int unsigned ST_OVERRUN = 6;
localparam int unsigned ST_BUSY = 7;

// semaphore bits: write bit0=claim,bit1=release; core id in bit 4
localparam int unsigned SEM_CLAIM = 0;
localparam int unsigned SEM_RELEASE = 1;
localparam int unsigned SEM_CORE = 4;
localparam int unsigned SEM_HELD = 0;
localparam int unsigned SEM_GRANTED = 1;

localparam logic [15:0] RETURN_ADDR = 16'h0000;

// injected error kinds
localparam logic [1:0] INJ_NONE = 2'h0;
localparam logic [1:0] INJ_COMPARE = 2'h1;
localparam logic [1:0] INJ_TIMEOUT = 2'h2;
localparam logic [1:0] INJ_OVERRUN = 2'h3;

typedef enum logic [1:0] {
    LBIST_IDLE,
    LBIST_SHIFT,
    LBIST_FINISH
} lbist_state_t;

endpackage

// ===== core/lbist_sem.sv
module lbist_sem
    import lbist_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic claim,
    input wire logic release_req,
    input wire logic core_id,
    output logic held,
    output logic owner,
    output logic granted
);
    logic held_d;
    logic owner_d;
    logic granted_d;

    // ----------------------------------------
    // ownership
    // ----------------------------------------
    always_comb
    begin
        held_d = held;
        owner_d = owner;
        granted_d = granted;
        if (claim)
        begin
            // one grant at a time; a non-owner sees false
            if (!held || owner == core_id)
            begin
                held_d = 1'b1;
                owner_d = core_id;
                granted_d = 1'b1;
            end
            else
            begin
                granted_d = 1'b0;
            end
        end
        else if (release_req && held && owner == core_id)
        begin
            held_d = 1'b0;
            granted_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            held <= 1'b0;
            owner <= 1'b0;
            granted <= 1'b0;
        end
        else
        begin
            held <= held_d;
            owner <= owner_d;
            granted <= granted_d;
        end
    end

    a_sem_refuse: assert property (@(posedge clock) disable iff (!arst_n)
        claim && held && owner != core_id |=> !granted && $stable(owner))
        else $error("semaphore granted to non-owner");
endmodule

// ===== core/lbist_slice.sv
module lbist_slice
    import lbist_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [CYC_CNT_W-1:0] length,
    output logic active,
    output logic last
);
    logic [CYC_CNT_W-1:0] cnt_q;
    logic [CYC_CNT_W-1:0] cnt_d;
    logic active_d;

    // ----------------------------------------
    // slice timer
    // ----------------------------------------
    always_comb
    begin
        cnt_d = cnt_q;
        active_d = active;
        if (abort)
        begin
            active_d = 1'b0;
        end
        else if (start && !active)
        begin
            active_d = 1'b1;
            cnt_d = length - 16'h0001;
        end
        else if (active)
        begin
            if (cnt_q == '0)
                active_d = 1'b0;
            else
                cnt_d = cnt_q - 16'h0001;
        end
    end

    assign last = active && cnt_q == '0;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            active <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            active <= active_d;
        end
    end
endmodule

// ===== core/lbist_ctrl.sv
// Strobed register access and the address map were decided locally.
module lbist_ctrl
    import lbist_pkg::*;
#(
    parameter int unsigned RUNS_LOW_P = RUNS_LOW,
    parameter int unsigned RUNS_HIGH_P = RUNS_HIGH,
    parameter int unsigned TIMEOUT_P = TIMEOUT_CYC
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic ext_nmi,
    input wire logic compare_fail_in,
    output logic [15:0] rdata,
    output logic scan_enable,
    output logic coverage_high_stuck_at,
    output logic nmi_out,
    output logic [15:0] resume_addr
);
    if (RUNS_LOW_P < 1 || RUNS_LOW_P >= (1 << RUN_CNT_W) || RUNS_HIGH_P < 1
        || RUNS_HIGH_P >= (1 << RUN_CNT_W) || TIMEOUT_P <= CYC_HIGH || TIMEOUT_P >= (1 << CYC_CNT_W))
    begin
        $error("lbist_ctrl: parameter out of range");
    end

    localparam logic [RUN_CNT_W-1:0] TGT_LOW = RUN_CNT_W'(RUNS_LOW_P);
    localparam logic [RUN_CNT_W-1:0] TGT_HIGH = RUN_CNT_W'(RUNS_HIGH_P);
    localparam logic [CYC_CNT_W-1:0] TO_LIM = CYC_CNT_W'(TIMEOUT_P);

    lbist_state_t state_q;
    lbist_state_t state_d;
    logic [RUN_CNT_W-1:0] runs_q;
    logic [RUN_CNT_W-1:0] runs_d;
    logic [CYC_CNT_W-1:0] wd_q;
    logic [CYC_CNT_W-1:0] wd_d;
    logic cov_high_q;
    logic cov_high_d;
    logic inited_q;
    logic inited_d;
    logic [1:0] inject_q;
    logic [1:0] inject_d;
    logic done_q, done_d;
    logic micro_q, micro_d;
    logic nmi_q, nmi_d;
    logic comp_q, comp_d;
    logic to_q, to_d;
    logic over_q, over_d;
    logic [15:0] rdata_d;
    logic sem_held, sem_owner, sem_granted;
    logic slice_active, slice_last;
    logic slice_start;
    logic init_req, micro_req;

    function automatic logic is_wr(input logic [3:0] a);
        is_wr = wr && addr == a;
    endfunction

    assign init_req = is_wr(ADDR_CTRL) && wdata[CTRL_INIT] && sem_held;
    // micro-runs need the semaphore and an init first
    assign micro_req = is_wr(ADDR_CTRL) && wdata[CTRL_MICRO] && sem_held && inited_q;
    // init wins over a micro-run requested in the same write
    assign slice_start = state_q == LBIST_IDLE && micro_req && !done_q && !init_req;

    // ----------------------------------------
    // semaphore and slice timer
    // ----------------------------------------
    lbist_sem u_sem (
        .clock(clock),
        .arst_n(arst_n),
        .claim(is_wr(ADDR_SEM) && wdata[SEM_CLAIM]),
        .release_req(is_wr(ADDR_SEM) && wdata[SEM_RELEASE]),
        .core_id(wdata[SEM_CORE]),
        .held(sem_held),
        .owner(sem_owner),
        .granted(sem_granted)
    );

    lbist_slice u_slice (
        .clock(clock),
        .arst_n(arst_n),
        .start(slice_start),
        // idle kills a slice left over by a time-out, never the one being started
        .abort(state_q == LBIST_IDLE && !slice_start),
        .length(cov_high_q ? CYC_CNT_W'(CYC_HIGH) : CYC_CNT_W'(CYC_LOW)),
        .active(slice_active),
        .last(slice_last)
    );

    // ----------------------------------------
    // engine sequencing and status
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        runs_d = runs_q;
        wd_d = wd_q;
        cov_high_d = cov_high_q;
        inited_d = inited_q;
        inject_d = inject_q;
        done_d = done_q;
        micro_d = micro_q;
        nmi_d = nmi_q || ext_nmi;
        comp_d = comp_q;
        to_d = to_q;
        over_d = over_q;
        case (state_q)
            LBIST_IDLE:
            begin
                if (init_req)
                begin
                    // reinit clears count and flags, loads target
                    runs_d = '0;
                    cov_high_d = wdata[CTRL_COV_HIGH];
                    inited_d = 1'b1;
                    inject_d = INJ_NONE;
                    {done_d, micro_d, comp_d, to_d, over_d} = 5'h00;
                    // an nmi arriving with the reinit is kept: the set wins
                    nmi_d = ext_nmi;
                end
                else if (is_wr(ADDR_INJECT) && inited_q && runs_q == '0)
                begin
                    inject_d = wdata[1:0];
                end
                else if (slice_start)
                begin
                    micro_d = 1'b0;
                    wd_d = '0;
                    state_d = LBIST_SHIFT;
                end
            end
            LBIST_SHIFT:
            begin
                // test clock is the system clock: one shift per edge
                wd_d = wd_q + 16'h0001;
                if ((wd_q >= TO_LIM - 16'h0001) || inject_q == INJ_TIMEOUT)
                begin
                    to_d = 1'b1;
                    state_d = LBIST_FINISH;
                end
                else if (slice_last)
                begin
                    state_d = LBIST_FINISH;
                end
            end
            LBIST_FINISH:
            begin
                micro_d = 1'b1;
                runs_d = runs_q + 12'h001;
                if (compare_fail_in || inject_q == INJ_COMPARE)
                    comp_d = 1'b1;
                if (runs_q + 12'h001 >= (cov_high_q ? TGT_HIGH : TGT_LOW))
                begin
                    done_d = 1'b1;
                    // coverage must be signed off by the final run
                    if (inject_q == INJ_OVERRUN)
                        over_d = 1'b1;
                end
                state_d = LBIST_IDLE;
            end
            default:
            begin
                state_d = LBIST_IDLE;
            end
        endcase
        if (comp_d || to_d)
        begin
            done_d = 1'b1;
            nmi_d = 1'b1;
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_comb
    begin
        rdata_d = 16'h0000;
        if (rd)
        begin
            case (addr)
                ADDR_STATUS:
                begin
                    rdata_d[ST_DONE] = done_q;
                    rdata_d[ST_MICRO_DONE] = micro_q;
                    rdata_d[ST_NMI] = nmi_q;
                    rdata_d[ST_FAIL] = comp_q || to_q;
                    rdata_d[ST_COMP_FAIL] = comp_q;
                    rdata_d[ST_TO_FAIL] = to_q;
                    rdata_d[ST_OVERRUN] = over_q;
                    rdata_d[ST_BUSY] = state_q != LBIST_IDLE;
                end
                ADDR_CTRL: rdata_d = {13'h0000, 1'b0, cov_high_q, inited_q};
                ADDR_COUNT: rdata_d = {4'h0, runs_q};
                ADDR_SEM: rdata_d = {11'h000, sem_owner, 2'h0, sem_granted, sem_held};
                ADDR_RETADDR: rdata_d = RETURN_ADDR;
                ADDR_INJECT: rdata_d = {14'h0000, inject_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= LBIST_IDLE;
            runs_q <= '0;
            wd_q <= '0;
            cov_high_q <= 1'b0;
            inited_q <= 1'b0;
            inject_q <= INJ_NONE;
            {done_q, micro_q, nmi_q, comp_q, to_q, over_q} <= 6'h00;
            rdata <= 16'h0000;
            scan_enable <= 1'b0;
            coverage_high_stuck_at <= 1'b0;
            nmi_out <= 1'b0;
            resume_addr <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            runs_q <= runs_d;
            wd_q <= wd_d;
            cov_high_q <= cov_high_d;
            inited_q <= inited_d;
            inject_q <= inject_d;
            done_q <= done_d;
            micro_q <= micro_d;
            nmi_q <= nmi_d;
            comp_q <= comp_d;
            to_q <= to_d;
            over_q <= over_d;
            rdata <= rdata_d;
            scan_enable <= state_d == LBIST_SHIFT;
            // pattern set: launch-on-shift low, stuck-at high
            coverage_high_stuck_at <= cov_high_d;
            nmi_out <= nmi_d;
            resume_addr <= RETURN_ADDR;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_micro_len: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(scan_enable) && !cov_high_q && inject_q == INJ_NONE |-> scan_enable [*8])
        else $error("micro-run too short");
    a_micro_flag: assert property (@(posedge clock) disable iff (!arst_n)
        state_q == LBIST_FINISH |=> micro_q && runs_q == $past(runs_q) + 12'h001)
        else $error("micro-run completion not flagged");
    a_done_count: assert property (@(posedge clock) disable iff (!arst_n)
        state_q == LBIST_FINISH && !cov_high_q && runs_q == TGT_LOW - 12'h001 |=> done_q)
        else $error("low pass done missing");
    a_done_high: assert property (@(posedge clock) disable iff (!arst_n)
        state_q == LBIST_FINISH && cov_high_q && runs_q == TGT_HIGH - 12'h001 |=> done_q)
        else $error("high pass done missing");
    a_nmi_cause: assert property (@(posedge clock) disable iff (!arst_n)
        (comp_q || to_q) |-> nmi_q && nmi_out)
        else $error("nmi missing for failure");
    a_fail_done: assert property (@(posedge clock) disable iff (!arst_n)
        to_q |-> done_q)
        else $error("done missing on error");
    a_comp_set: assert property (@(posedge clock) disable iff (!arst_n)
        state_q == LBIST_FINISH && compare_fail_in |=> comp_q && state_q == LBIST_IDLE)
        else $error("compare fail not captured");
    a_flag_hold: assert property (@(posedge clock) disable iff (!arst_n)
        done_q && !init_req |=> done_q)
        else $error("done dropped before reinit");
    a_init_clear: assert property (@(posedge clock) disable iff (!arst_n)
        init_req && state_q == LBIST_IDLE |=> runs_q == '0 && !done_q)
        else $error("reinit did not clear");
    a_timeout: assert property (@(posedge clock) disable iff (!arst_n)
        state_q == LBIST_SHIFT && inject_q == INJ_TIMEOUT |=> to_q ##1 done_q)
        else $error("time-out not flagged");
endmodule

// ===== verification/lbist_core_model.sv
module lbist_core_model
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scan_enable,
    input wire logic fault,
    output logic compare_fail_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // captured response of the core under test
    // ----------------------------------------
    logic shift_q;
    logic pat_q;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shift_q <= 1'b0;
            pat_q <= 1'b0;
        end
        else
        begin
            shift_q <= scan_enable;
            pat_q <= ~pat_q;
        end
    end

    // response only means something in and just after a slice; elsewhere it churns
    assign compare_fail_in = (scan_enable | shift_q) ? fault : pat_q;
endmodule

// ===== verification/tb_cpu_logic_bist_controller.sv
module tb_cpu_logic_bist_controller;
    import lbist_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // clock, reset and design
    // ----------------------------------------
    localparam int RL = 3;
    localparam int RH = 2;
    localparam int TO = 100;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_nmi = 1'b0;
    logic fault = 1'b0;
    logic compare_fail_in;
    logic [15:0] rdata;
    logic scan_enable;
    logic coverage_high_stuck_at;
    logic nmi_out;
    logic [15:0] resume_addr;
    logic rd_pend = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    int err_count = 0;
    int checks_done = 0;
    integer seed = 32'h6EFAA70E;
    int fr;

    initial
    begin
        forever #25 clock = ~clock;
    end

    lbist_ctrl #(.RUNS_LOW_P(RL), .RUNS_HIGH_P(RH), .TIMEOUT_P(TO)) dut (
        .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .ext_nmi(ext_nmi), .compare_fail_in(compare_fail_in), .rdata(rdata),
        .scan_enable(scan_enable), .coverage_high_stuck_at(coverage_high_stuck_at),
        .nmi_out(nmi_out), .resume_addr(resume_addr));

    lbist_core_model core (.clock(clock), .arst_n(arst_n), .scan_enable(scan_enable),
        .fault(fault), .compare_fail_in(compare_fail_in));

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // masked bits are those whose value is left open, e.g. busy while a slice hangs
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
    endtask

    task automatic micro(input int len);
        int n;
        n = 0;
        wr_reg(ADDR_CTRL, 16'h0004);
        for (int i = 0; i < 20 && scan_enable !== 1'b1; i++)
            @(negedge clock);
        while (scan_enable === 1'b1 && n < 200)
        begin
            n++;
            @(negedge clock);
        end
        chk_val(16'(n), 16'(len));
        repeat (4) @(posedge clock);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // read data watcher
    // ----------------------------------------
    always @(posedge clock)
        rd_pend <= rd;

    always @(negedge clock)
    begin
        logic [15:0] e;
        logic [15:0] m;
        if (rd_pend === 1'b1)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk_val(rdata & m, e & m);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        end_sim();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        wr_reg(4'hF, 16'($random(seed)));
        rd_reg(4'hF, 16'h0000);
        rd_reg(ADDR_RETADDR, RETURN_ADDR);
        rd_reg(ADDR_STATUS, 16'h0000);
        chk_val(resume_addr, 16'h0000);
        wr_reg(ADDR_CTRL, 16'h0001);
        rd_reg(ADDR_CTRL, 16'h0000);
        wr_reg(ADDR_SEM, 16'h0001);
        rd_reg(ADDR_SEM, 16'h0003);
        wr_reg(ADDR_SEM, 16'h0011);
        rd_reg(ADDR_SEM, 16'h0001);
        wr_reg(ADDR_SEM, 16'h0012);
        rd_reg(ADDR_SEM, 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0001);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(ADDR_INJECT, 16'(k));
            rd_reg(ADDR_INJECT, 16'(k));
        end
        wr_reg(ADDR_INJECT, 16'h0000);
        for (int i = 0; i < RL; i++)
        begin
            micro(CYC_LOW);
            rd_reg(ADDR_STATUS, (i == RL - 1) ? 16'h0003 : 16'h0002);
            rd_reg(ADDR_COUNT, 16'(i + 1));
        end
        wr_reg(ADDR_CTRL, 16'h0004);
        rd_reg(ADDR_COUNT, 16'(RL));
        chk_val(16'(coverage_high_stuck_at), 16'h0000);
        wr_reg(ADDR_CTRL, 16'h0003);
        rd_reg(ADDR_CTRL, 16'h0003);
        rd_reg(ADDR_COUNT, 16'h0000);
        rd_reg(ADDR_STATUS, 16'h0000);
        chk_val(16'(coverage_high_stuck_at), 16'h0001);
        for (int i = 0; i < RH; i++)
        begin
            micro(CYC_HIGH);
            rd_reg(ADDR_STATUS, (i == RH - 1) ? 16'h0003 : 16'h0002);
        end
        // the failing slice is picked at random so the count check is not one fixed case
        fr = ($random(seed) & 32'h1);
        wr_reg(ADDR_CTRL, 16'h0001);
        for (int i = 0; i <= fr; i++)
        begin
            fault <= (i == fr);
            micro(CYC_LOW);
        end
        fault <= 1'b0;
        rd_reg(ADDR_STATUS, 16'h001F);
        rd_reg(ADDR_COUNT, 16'(fr + 1));
        chk_val(16'(nmi_out), 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0001);
        rd_reg(ADDR_STATUS, 16'h0000);
        @(posedge clock);
        ext_nmi <= 1'b1;
        @(posedge clock);
        ext_nmi <= 1'b0;
        repeat (2) @(posedge clock);
        rd_reg(ADDR_STATUS, 16'h0004, 16'h003C);
        chk_val(16'(nmi_out), 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0001);
        wr_reg(ADDR_INJECT, 16'h0002);
        wr_reg(ADDR_CTRL, 16'h0004);
        repeat (TO + 100) @(posedge clock);
        rd_reg(ADDR_STATUS, 16'h002D, 16'h007D);
        // injected compare error ends the pass after one micro-run
        wr_reg(ADDR_CTRL, 16'h0001);
        wr_reg(ADDR_INJECT, 16'(INJ_COMPARE));
        micro(CYC_LOW);
        rd_reg(ADDR_STATUS, 16'h001F);
        // injected overrun shows only when the pass reaches its count
        wr_reg(ADDR_CTRL, 16'h0001);
        wr_reg(ADDR_INJECT, 16'(INJ_OVERRUN));
        for (int i = 0; i < RL; i++)
            micro(CYC_LOW);
        rd_reg(ADDR_STATUS, 16'h0043);
        wr_reg(ADDR_SEM, 16'h0002);
        wr_reg(ADDR_SEM, 16'h0011);
        rd_reg(ADDR_SEM, 16'h0013);
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule
